// file: common/prog_pkg.sv
// Shared types and constants of the programming sequencer
package prog_pkg;

  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned WORD_W       = 14;
  localparam int unsigned ROW_WORDS    = 32;
  localparam int unsigned LAT_W        = 5;

  // Address ranges
  localparam logic [15:0] PROG_TOP     = 16'h7fff;
  localparam logic [15:0] CFG_BASE     = 16'h8000;
  localparam logic [15:0] UID_TOP      = 16'h8008;

  // Link commands (six-bit codes)
  localparam logic [5:0] CMD_LOAD_CFG  = 6'h00;
  localparam logic [5:0] CMD_LOAD_PGM  = 6'h02;
  localparam logic [5:0] CMD_LOAD_DAT  = 6'h03;
  localparam logic [5:0] CMD_READ_PGM  = 6'h04;
  localparam logic [5:0] CMD_READ_DAT  = 6'h05;
  localparam logic [5:0] CMD_INC_ADDR  = 6'h06;
  localparam logic [5:0] CMD_RST_ADDR  = 6'h16;
  localparam logic [5:0] CMD_BEGIN_INT = 6'h08;
  localparam logic [5:0] CMD_BEGIN_EXT = 6'h18;
  localparam logic [5:0] CMD_END_EXT   = 6'h0a;
  localparam logic [5:0] CMD_BULK_PGM  = 6'h09;
  localparam logic [5:0] CMD_BULK_DAT  = 6'h0b;
  localparam logic [5:0] CMD_ROW_ERASE = 6'h11;

  // Times, in their printed units, and derived cycle counts
  localparam int unsigned BULK_ERASE_MS10  = 50;
  localparam int unsigned ROW_ERASE_MS10   = 25;
  localparam int unsigned INT_WRITE_MS10   = 25;
  localparam int unsigned DISCHARGE_US     = 300;
  localparam int unsigned BULK_ERASE_CYC   = BULK_ERASE_MS10 * 100 * CLK_MHZ;
  localparam int unsigned ROW_ERASE_CYC    = ROW_ERASE_MS10 * 100 * CLK_MHZ;
  localparam int unsigned INT_WRITE_CYC    = INT_WRITE_MS10 * 100 * CLK_MHZ;
  localparam int unsigned DISCHARGE_CYC    = DISCHARGE_US * CLK_MHZ;
  localparam int unsigned TIMER_W          = 24;

  localparam logic [2:0] SYNC_RESET    = 3'h0;
  localparam logic [15:0] ADDR_RESET   = 16'h0000;

  typedef enum logic [2:0] {
    OP_NONE, OP_BULK_PGM, OP_BULK_DAT, OP_ROW_ERASE, OP_WRITE
  } op_t;

  // Command word carried across clock domains
  typedef struct packed {
    logic [5:0]  code;
    logic [13:0] data;
  } cmd_t;

  // Memory side request to the array
  typedef struct packed {
    logic        erase_pgm;
    logic        erase_cfg;
    logic        erase_uid;
    logic        erase_dat;
    logic        erase_row;
    logic        write_row;
    logic        write_dat;
    logic [15:0] addr;
  } mem_req_t;

endpackage : prog_pkg

// file: logic/link_shift.sv
// Link side receiver: shifts commands and data on the link clock
`timescale 1ns/1ns
module link_shift
  import prog_pkg::*;
(
  input  wire logic              link_clk,
  input  wire logic              link_reset,
  input  wire logic              dat_in,
  output prog_pkg::cmd_t         cmd_word,
  output logic                   cmd_toggle
);
  import prog_pkg::*;

  typedef enum logic [1:0] {ST_CMD, ST_DATA} shift_state_t;

  shift_state_t state_ff;
  logic [5:0]   cnt_ff;
  logic [15:0]  sh_ff;
  logic [5:0]   code_ff;
  cmd_t         word_ff;
  logic         tog_ff;

  // Commands with a sixteen-clock payload
  function automatic logic has_data(input logic [5:0] c);
    has_data = (c == CMD_LOAD_CFG) || (c == CMD_LOAD_PGM) || (c == CMD_LOAD_DAT);
  endfunction : has_data

  // ----------------------------------------
  // Shift and frame
  // ----------------------------------------
  always_ff @(posedge link_clk)
  begin
    if (link_reset)
    begin
      state_ff <= ST_CMD;
      cnt_ff   <= 6'h00;
      sh_ff    <= 16'h0000;
      code_ff  <= 6'h00;
      word_ff  <= '0;
      tog_ff   <= 1'b0;
    end
    else
    begin
      sh_ff <= {dat_in, sh_ff[15:1]};
      unique case (state_ff)
        ST_CMD:
        begin
          if (cnt_ff == 6'h05)
          begin
            cnt_ff <= 6'h00;
            if (has_data({dat_in, sh_ff[15:11]}))
            begin
              code_ff  <= {dat_in, sh_ff[15:11]};
              state_ff <= ST_DATA;
            end
            else
            begin
              word_ff <= '{code: {dat_in, sh_ff[15:11]}, data: 14'h0000};
              tog_ff  <= ~tog_ff;
            end
          end
          else
            cnt_ff <= cnt_ff + 6'h01;
        end
        ST_DATA:
        begin
          if (cnt_ff == 6'h0f)
          begin
            cnt_ff   <= 6'h00;
            state_ff <= ST_CMD;
            word_ff  <= '{code: code_ff, data: sh_ff[15:2]};
            tog_ff   <= ~tog_ff;
          end
          else
            cnt_ff <= cnt_ff + 6'h01;
        end
      endcase
    end
  end

  assign cmd_word   = word_ff;
  assign cmd_toggle = tog_ff;

endmodule : link_shift

// file: logic/prog_erase_write_protect.sv
// Programming sequencer: erase, latch, write and protection gating
`timescale 1ns/1ns
//
// Overview of operation
// (RQ1) Programmer must end external write in window
// (RQ2) Programmer waits discharge delay after end
// (RQ3) Bulk erase low: program, config, data; code erases data only when data protection is on
// (RQ4) Bulk erase high: also user IDs
// (RQ5) Programmer avoids bulk erase above 8008h
// (RQ6) Data bulk erase busy for bulk time
// (RQ7) Protected data erased by program bulk
// (RQ8) Program bulk erase busy for bulk time
// (RQ9) Program protection never blocks bulk erase
// (RQ10) Row erase clears 32 words, addr[15:5]
// (RQ11) Row erase ignored when protected, non-ID
// (RQ12) Row erase at IDs erases IDs only
// (RQ13) Row erase busy for row erase time
// (RQ14) Thirty-two 14-bit latches hold loaded words
// (RQ15) Low bits pick latch, high bits row
// (RQ16) Extra loads overwrite earlier latched words
// (RQ17) Program protection zeroes reads, blocks writes
// (RQ18) Data protection zeroes reads, blocks writes
// (RQ19) IDs and config always readable, writable
// (RQ20) Only program bulk erase clears protection
// (RQ21) External write window 1.0 to 2.1 ms
// (RQ22) Bulk erase time at most 5 ms
// (RQ23) Row erase time at most 2.5 ms
// (RQ24) Discharge delay at least 300 us
module prog_erase_write_protect
  import prog_pkg::*;
#(
  // (RQ22) Bulk erase time
  parameter int unsigned BULK_CYC  = BULK_ERASE_CYC,
  // (RQ23) Row erase time
  parameter int unsigned ROW_CYC   = ROW_ERASE_CYC,
  parameter int unsigned WRITE_CYC = INT_WRITE_CYC
)
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              link_clk,
  input  wire logic              dat_in,
  input  wire logic              program_protect_n,
  input  wire logic              data_protect_n,
  input  wire logic [13:0]       mem_rd_data,
  output prog_pkg::mem_req_t     mem_req,
  output logic                   mem_req_valid,
  output logic [13:0]            row_latch_data [ROW_WORDS],
  output logic                   protect_clear,
  output logic [13:0]            read_data,
  output logic                   read_valid,
  output logic [15:0]            address,
  output logic                   busy
);
  import prog_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_BUSY, S_EXT} seq_state_t;

  // ----------------------------------------
  // Link side and crossing
  // ----------------------------------------
  cmd_t        link_word;
  logic        link_tog;
  logic [2:0]  link_rst_sync_ff;
  logic [2:0]  tog_sync_ff;
  logic        tog_seen_ff;
  cmd_t        cmd_ff;
  logic        cmd_stb;

  // Link reset follows system reset into the link domain
  always_ff @(posedge link_clk)
  begin
    if (reset)
      link_rst_sync_ff <= 3'b111;
    else
      link_rst_sync_ff <= {link_rst_sync_ff[1:0], 1'b0};
  end

  link_shift u_link_shift (
    .link_clk   (link_clk),
    .link_reset (link_rst_sync_ff[2]),
    .dat_in     (dat_in),
    .cmd_word   (link_word),
    .cmd_toggle (link_tog)
  );

  // Toggle crossing: word is stable while toggle settles
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tog_sync_ff <= SYNC_RESET;
      tog_seen_ff <= 1'b0;
    end
    else
    begin
      tog_sync_ff <= {tog_sync_ff[1:0], link_tog};
      // Toggle consumed only once strobed
      if (cmd_stb)
        tog_seen_ff <= tog_sync_ff[1];
    end
  end

  assign cmd_stb = (tog_sync_ff[2] == tog_sync_ff[1]) && (tog_sync_ff[1] != tog_seen_ff);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cmd_ff <= '0;
    else if (tog_sync_ff[2] != tog_sync_ff[1])
      cmd_ff <= link_word;
  end

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic in_uid(input logic [15:0] a);
    in_uid = (a >= CFG_BASE) && (a <= UID_TOP);
  endfunction : in_uid

  function automatic logic in_prog(input logic [15:0] a);
    in_prog = (a <= PROG_TOP);
  endfunction : in_prog

  logic [15:0]          addr_ff;
  seq_state_t           state_ff;
  logic [TIMER_W-1:0]   timer_ff;
  logic [13:0]          latch_ff [ROW_WORDS];
  mem_req_t             req_ff;
  logic                 req_valid_ff;
  logic                 clr_ff;
  logic [13:0]          rdata_ff;
  logic                 rvalid_ff;
  logic                 dat_blocked;
  logic                 pgm_blocked;
  logic                 dat_load_ff;

  // Protection gating of the current address
  // (RQ17) Program range blocked
  assign pgm_blocked = !program_protect_n && in_prog(addr_ff);
  // (RQ18) Data memory blocked
  assign dat_blocked = !data_protect_n;

  // ----------------------------------------
  // Address counter
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      addr_ff <= ADDR_RESET;
    else if (cmd_stb && state_ff == S_IDLE)
    begin
      if (cmd_ff.code == CMD_LOAD_CFG)
        addr_ff <= CFG_BASE;
      else if (cmd_ff.code == CMD_RST_ADDR)
        addr_ff <= ADDR_RESET;
      else if (cmd_ff.code == CMD_INC_ADDR)
        addr_ff <= (addr_ff == PROG_TOP) ? ADDR_RESET :
                   (addr_ff == 16'hffff) ? CFG_BASE : addr_ff + 16'h0001;
    end
  end

  // ----------------------------------------
  // Write latches
  // ----------------------------------------
  // (RQ14) One latch per load
  // (RQ16) Later loads overwrite
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < ROW_WORDS; i++)
        latch_ff[i] <= 14'h3fff;
    end
    else if (cmd_stb && state_ff == S_IDLE &&
             (cmd_ff.code == CMD_LOAD_PGM || cmd_ff.code == CMD_LOAD_DAT))
      latch_ff[addr_ff[LAT_W-1:0]] <= cmd_ff.data;
    else if (cmd_stb && state_ff == S_IDLE && cmd_ff.code == CMD_LOAD_CFG)
      latch_ff[0] <= cmd_ff.data;
  end

  assign row_latch_data = latch_ff;

  // (RQ18) Kind of last load
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      dat_load_ff <= 1'b0;
    else if (cmd_stb && state_ff == S_IDLE)
    begin
      if (cmd_ff.code == CMD_LOAD_DAT)
        dat_load_ff <= 1'b1;
      else if (cmd_ff.code == CMD_LOAD_PGM || cmd_ff.code == CMD_LOAD_CFG)
        dat_load_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sequencer and erase decode
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_ff     <= S_IDLE;
      timer_ff     <= '0;
      req_ff       <= '0;
      req_valid_ff <= 1'b0;
      clr_ff       <= 1'b0;
    end
    else
    begin
      req_valid_ff <= 1'b0;
      clr_ff       <= 1'b0;
      unique case (state_ff)
        S_IDLE:
        begin
          if (cmd_stb)
          begin
            req_ff      <= '0;
            req_ff.addr <= addr_ff;
            unique case (cmd_ff.code)
              CMD_BULK_PGM:
              begin
                // (RQ3) Low range erase set
                // (RQ4) High range adds IDs
                // (RQ9) Program protection ignored here
                req_ff.erase_pgm <= 1'b1;
                req_ff.erase_cfg <= 1'b1;
                req_ff.erase_uid <= in_uid(addr_ff);
                req_ff.erase_dat <= dat_blocked;
                req_valid_ff     <= 1'b1;
                // (RQ20) Only path to unprotect
                clr_ff           <= 1'b1;
                // (RQ8) Held busy for bulk time
                timer_ff         <= TIMER_W'(BULK_CYC);
                state_ff         <= S_BUSY;
              end
              CMD_BULK_DAT:
              begin
                // (RQ6) Data erase busy interval
                req_ff.erase_dat <= !dat_blocked;
                req_valid_ff     <= !dat_blocked;
                timer_ff         <= TIMER_W'(BULK_CYC);
                state_ff         <= S_BUSY;
              end
              CMD_ROW_ERASE:
              begin
                // (RQ12) IDs only in ID range
                // (RQ11) Ignored when protected
                // (RQ10) Row from addr[15:5]
                if (in_uid(addr_ff))
                begin
                  req_ff.erase_uid <= 1'b1;
                  req_valid_ff     <= 1'b1;
                end
                else if (program_protect_n)
                begin
                  req_ff.erase_row <= 1'b1;
                  req_ff.addr      <= {addr_ff[15:LAT_W], 5'h00};
                  req_valid_ff     <= 1'b1;
                end
                // (RQ13) Row erase busy interval
                timer_ff <= TIMER_W'(ROW_CYC);
                state_ff <= S_BUSY;
              end
              CMD_BEGIN_INT, CMD_BEGIN_EXT:
              begin
                // (RQ15) Row taken at write start
                // (RQ19) IDs and config never blocked
                req_ff.addr      <= {addr_ff[15:LAT_W], 5'h00};
                req_ff.write_row <= !dat_load_ff && !pgm_blocked &&
                                    !(cmd_ff.code == CMD_BEGIN_EXT && addr_ff > UID_TOP);
                // (RQ18) Data write blocked
                req_ff.write_dat <= dat_load_ff && !dat_blocked;
                req_valid_ff     <= dat_load_ff ? !dat_blocked : !pgm_blocked;
                timer_ff         <= TIMER_W'(WRITE_CYC);
                state_ff         <= (cmd_ff.code == CMD_BEGIN_EXT) ? S_EXT : S_BUSY;
              end
              default:
              begin
              end
            endcase
          end
        end
        S_BUSY:
        begin
          if (timer_ff <= TIMER_W'(1))
            state_ff <= S_IDLE;
          else
            timer_ff <= timer_ff - TIMER_W'(1);
        end
        S_EXT:
        begin
          // (RQ1) Write held until end command
          if (cmd_stb && cmd_ff.code == CMD_END_EXT)
            state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read path with protection masking
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rdata_ff  <= 14'h0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= cmd_stb && state_ff == S_IDLE &&
                   (cmd_ff.code == CMD_READ_PGM || cmd_ff.code == CMD_READ_DAT);
      if (cmd_stb && cmd_ff.code == CMD_READ_PGM)
        // (RQ17) Zero when protected
        rdata_ff <= pgm_blocked ? 14'h0000 : mem_rd_data;
      else if (cmd_stb && cmd_ff.code == CMD_READ_DAT)
        // (RQ18) Zero when protected
        rdata_ff <= dat_blocked ? 14'h0000 : {6'h00, mem_rd_data[7:0]};
    end
  end

  assign mem_req       = req_ff;
  assign mem_req_valid = req_valid_ff;
  assign protect_clear = clr_ff;
  assign read_data     = rdata_ff;
  assign read_valid    = rvalid_ff;
  assign address       = addr_ff;
  assign busy          = (state_ff != S_IDLE);

endmodule : prog_erase_write_protect

// file: verif/prog_ewp_chk.sv
// Port assertions for the programming sequencer
`timescale 1ns/1ns
module prog_ewp_chk
  import prog_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               reset,
  input wire logic               program_protect_n,
  input wire logic               data_protect_n,
  input wire prog_pkg::mem_req_t mem_req,
  input wire logic               mem_req_valid,
  input wire logic               protect_clear,
  input wire logic [13:0]        read_data,
  input wire logic               read_valid,
  input wire logic [15:0]        address,
  input wire logic               busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_row_align: assert property (
    mem_req_valid && mem_req.erase_row |-> mem_req.addr[4:0] == 5'h00)
    else $error("row erase not row aligned");
  a_write_align: assert property (
    mem_req_valid && mem_req.write_row |-> mem_req.addr[4:0] == 5'h00)
    else $error("row write not row aligned");
  a_req_busy: assert property (
    mem_req_valid |-> busy)
    else $error("request without busy");
  a_bulk_hold: assert property (
    mem_req_valid && mem_req.erase_pgm |=> busy [*8])
    else $error("bulk erase ended early");
  a_bulk_cfg: assert property (
    mem_req_valid && mem_req.erase_pgm |->
      mem_req.erase_cfg && (mem_req.erase_dat == !data_protect_n))
    else $error("bulk erase targets wrong");
  a_bulk_clear: assert property (
    mem_req_valid && mem_req.erase_pgm |-> protect_clear)
    else $error("bulk erase without clear");
  a_clear_cause: assert property (
    protect_clear |-> mem_req_valid && mem_req.erase_pgm)
    else $error("clear without bulk erase");
  a_uid_only: assert property (
    mem_req_valid && mem_req.erase_uid && !mem_req.erase_pgm |->
      !mem_req.erase_cfg && !mem_req.erase_dat)
    else $error("id erase touches more");
  a_row_guard: assert property (
    mem_req_valid && mem_req.erase_row |-> program_protect_n)
    else $error("protected row erased");
  a_dat_guard: assert property (
    mem_req_valid && mem_req.write_dat |-> data_protect_n)
    else $error("protected data written");
  a_read_zero: assert property (
    read_valid && !program_protect_n && !data_protect_n && address <= PROG_TOP
      |-> read_data == 14'h0000)
    else $error("protected read not zero");

  c_row: cover property (mem_req_valid && mem_req.erase_row);
  c_clear: cover property (protect_clear);
  c_zero: cover property (read_valid && read_data == 14'h0000);
endmodule : prog_ewp_chk

// file: verif/prog_link_model.sv
// Programmer model driving the serial programming link
`timescale 1ns/1ns
module prog_link_model
  import prog_pkg::*;
#(
  parameter int unsigned EXT_NS = 1000,
  parameter int unsigned DIS_NS = 3000
)
(
  output logic link_clk,
  output logic dat_in
);
  initial
  begin
    link_clk = 1'b0;
    dat_in   = 1'b0;
  end
  // Data set up while clock low, clock idles low
  task automatic tick(input logic b);
    dat_in = b;
    #62 link_clk = 1'b1;
    #63 link_clk = 1'b0;
  endtask : tick
  task automatic wake;
    repeat (3) tick(1'b0);
  endtask : wake
  task automatic send(input logic [5:0] c, input logic [13:0] d, input logic ld);
    logic [21:0] w;
    w = {1'b0, d, 1'b0, c};
    for (int i = 0; i < (ld ? 22 : 6); i++) tick(w[i]);
    dat_in = ~dat_in;
    #1000;
  endtask : send
  task automatic ext_pair;
    send(CMD_BEGIN_EXT, 14'h0000, 1'b0);
    #(EXT_NS);
    send(CMD_END_EXT, 14'h0000, 1'b0);
    #(DIS_NS);
  endtask : ext_pair
endmodule : prog_link_model

// file: verif/prog_erase_write_protect_tb.sv
// Testbench of the programming sequencer
`timescale 1ns/1ns
module prog_erase_write_protect_tb;
  import prog_pkg::*;
  localparam int unsigned SIM_CYC = 20;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        program_protect_n = 1'b1;
  logic        data_protect_n = 1'b1;
  logic        link_clk, dat_in, mem_req_valid, protect_clear, read_valid, busy;
  mem_req_t    mem_req, last_req;
  logic [13:0] row_latch_data [ROW_WORDS];
  logic [13:0] read_data, last_rd, mem_rd_data;
  logic [15:0] address;
  int          err_count = 0, checks_done = 0, req_n = 0, rd_n = 0, clr_n = 0, bsy = 0;

  always #2 clk_sys = ~clk_sys;
  // Array model: read word derived from address
  assign mem_rd_data = address[13:0] ^ 14'h2a5a;

  prog_erase_write_protect #(.BULK_CYC(SIM_CYC), .ROW_CYC(SIM_CYC), .WRITE_CYC(SIM_CYC)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .link_clk(link_clk), .dat_in(dat_in),
    .program_protect_n(program_protect_n), .data_protect_n(data_protect_n),
    .mem_rd_data(mem_rd_data), .mem_req(mem_req), .mem_req_valid(mem_req_valid),
    .row_latch_data(row_latch_data), .protect_clear(protect_clear), .read_data(read_data),
    .read_valid(read_valid), .address(address), .busy(busy));
  prog_link_model i_prog (.link_clk(link_clk), .dat_in(dat_in));

  always @(posedge clk_sys)
  begin
    if (mem_req_valid) last_req <= mem_req;
    if (read_valid) last_rd <= read_data;
    req_n <= req_n + int'(mem_req_valid);
    rd_n  <= rd_n + int'(read_valid);
    clr_n <= clr_n + int'(protect_clear);
    bsy   <= bsy + int'(busy);
  end

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmd(input logic [5:0] c, input logic [13:0] d = 14'h0000);
    i_prog.send(c, d, c inside {CMD_LOAD_CFG, CMD_LOAD_PGM, CMD_LOAD_DAT});
  endtask : cmd
  task automatic prot(input logic p, input logic d);
    @(negedge clk_sys);
    program_protect_n = p;
    data_protect_n = d;
  endtask : prot
  // Flags: pgm cfg uid dat row write_row
  task automatic exp_req(input logic [5:0] c, input logic [5:0] f, input logic [5:0] m,
                         input logic [15:0] a, input logic [15:0] am);
    int n, b, k;
    n = req_n;
    b = bsy;
    k = clr_n;
    cmd(c);
    cmp_val(16'(req_n - n), 16'h0001);
    cmp_val({10'h000, m & {last_req.erase_pgm, last_req.erase_cfg, last_req.erase_uid,
             last_req.erase_dat, last_req.erase_row, last_req.write_row}}, {10'h000, f & m});
    cmp_val(last_req.addr & am, a & am);
    cmp_val(16'(clr_n - k), {15'h0000, f[5]});
    cmp_val(16'(bsy - b == SIM_CYC), 16'h0001);
  endtask : exp_req
  task automatic exp_none(input logic [5:0] c);
    int n;
    n = req_n;
    cmd(c);
    cmp_val(16'(req_n - n), 16'h0000);
  endtask : exp_none
  task automatic exp_rd(input logic [5:0] c, input logic [13:0] e);
    int n;
    n = rd_n;
    cmd(c);
    cmp_val(16'(rd_n - n), 16'h0001);
    cmp_val({2'b00, last_rd}, {2'b00, e});
  endtask : exp_rd

  task automatic t_row;
    prot(1'b1, 1'b1);
    cmd(CMD_RST_ADDR);
    repeat (3) cmd(CMD_INC_ADDR);
    exp_req(CMD_ROW_ERASE, 6'h02, 6'h3f, 16'h0000, 16'hffff);
    prot(1'b0, 1'b1);
    exp_none(CMD_ROW_ERASE);
    cmd(CMD_LOAD_CFG, 14'h0123);
    repeat (2) cmd(CMD_INC_ADDR);
    exp_req(CMD_ROW_ERASE, 6'h08, 6'h3c, 16'h8000, 16'hffe0);
    repeat (7) cmd(CMD_INC_ADDR);
    exp_none(CMD_ROW_ERASE);
    cmd(CMD_LOAD_CFG, 14'h0123);
    $display("row erase test done");
  endtask : t_row
  task automatic t_bulk;
    exp_req(CMD_BULK_PGM, 6'h38, 6'h3e, 16'h0000, 16'h0000);
    cmd(CMD_RST_ADDR);
    prot(1'b1, 1'b0);
    exp_req(CMD_BULK_PGM, 6'h34, 6'h3e, 16'h0000, 16'h0000);
    prot(1'b1, 1'b1);
    exp_req(CMD_BULK_DAT, 6'h04, 6'h3e, 16'h0000, 16'h0000);
    prot(1'b1, 1'b0);
    exp_none(CMD_BULK_DAT);
    $display("bulk erase test done");
  endtask : t_bulk
  task automatic t_read;
    prot(1'b0, 1'b0);
    exp_rd(CMD_READ_PGM, 14'h0000);
    exp_rd(CMD_READ_DAT, 14'h0000);
    prot(1'b1, 1'b1);
    exp_rd(CMD_READ_PGM, 14'h2a5a);
    exp_rd(CMD_READ_DAT, 14'h005a);
    cmd(CMD_LOAD_CFG, 14'h0001);
    prot(1'b0, 1'b0);
    exp_rd(CMD_READ_PGM, 14'h2a5a ^ 14'h0000);
    $display("read test done");
  endtask : t_read
  task automatic t_latch;
    prot(1'b1, 1'b1);
    cmd(CMD_RST_ADDR);
    cmd(CMD_LOAD_PGM, 14'h1111);
    cmd(CMD_INC_ADDR);
    cmd(CMD_LOAD_PGM, 14'h2222);
    cmp_val({2'b00, row_latch_data[0]}, 16'h1111);
    cmd(CMD_LOAD_PGM, 14'h3333);
    cmp_val({2'b00, row_latch_data[1]}, 16'h3333);
    exp_req(CMD_BEGIN_INT, 6'h01, 6'h3f, 16'h0000, 16'hffff);
    cmd(CMD_LOAD_PGM, 14'h0444);
    i_prog.ext_pair();
    cmp_val({15'h0000, busy}, 16'h0000);
    prot(1'b0, 1'b1);
    cmd(CMD_LOAD_PGM, 14'h0555);
    exp_none(CMD_BEGIN_INT);
    cmd(CMD_LOAD_DAT, 14'h0066);
    exp_req(CMD_BEGIN_INT, 6'h00, 6'h01, 16'h0000, 16'h0000);
    cmp_val({15'h0000, last_req.write_dat}, 16'h0001);
    prot(1'b0, 1'b0);
    exp_none(CMD_BEGIN_INT);
    $display("latch and write test done");
  endtask : t_latch

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  initial
  begin
    i_prog.wake();
    repeat (6) @(negedge clk_sys);
    reset = 1'b0;
    i_prog.wake();
    repeat (10) @(negedge clk_sys);
    t_row();
    t_bulk();
    t_read();
    t_latch();
    close_out();
  end
  initial
  begin
    #300000;
    err_count++;
    close_out();
  end
endmodule : prog_erase_write_protect_tb

bind prog_erase_write_protect prog_ewp_chk i_chk (
  .clk_sys(clk_sys), .reset(reset), .program_protect_n(program_protect_n),
  .data_protect_n(data_protect_n), .mem_req(mem_req), .mem_req_valid(mem_req_valid),
  .protect_clear(protect_clear), .read_data(read_data), .read_valid(read_valid),
  .address(address), .busy(busy));
